// ### common/lpc_regs.svh
// Register map, field layout, reset values and timing figures
// Assumes inclusion by bare name from design files
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH

// Register indices on the serial port
`define LPC_REG_PAIR_A_CURRENT 8'h00
`define LPC_REG_PAIR_B_CURRENT 8'h01
`define LPC_REG_PAIR_C_CURRENT 8'h02
`define LPC_REG_CHANNEL_ON_OFF 8'h03
`define LPC_REG_COUNT          4

// Field layout
`define LPC_CODE_MSB   5
`define LPC_USED_MASK  8'h3f
`define LPC_REG_RESET  8'h00

// Fixed 7-bit slave address 1100110
`define LPC_SLAVE_ADDR 7'h66

// Pump mode switch delay
`define LPC_SWITCH_DELAY_US 400
`define LPC_CLK_MHZ         125
`define LPC_SWITCH_DELAY_CYC (`LPC_SWITCH_DELAY_US * `LPC_CLK_MHZ)

`endif

// ### common/lpc_pkg.sv
// Types shared by the LED pair current control block
// Assumes the constants of lpc_regs.svh
package lpc_pkg;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_RX   = 3'b001,
    I2C_ACK  = 3'b010,
    I2C_TX   = 3'b011,
    I2C_RACK = 3'b100
  } lpc_i2c_st_t;

  typedef enum logic [1:0] {
    KB_ADDR = 2'b00,
    KB_PTR  = 2'b01,
    KB_DATA = 2'b10
  } lpc_kind_t;

  typedef enum logic {
    PUMP_1X   = 1'b0,
    PUMP_1P5X = 1'b1
  } lpc_pump_t;

  typedef struct packed {
    logic [2:0]       scl_sy;
    logic [2:0]       sda_sy;
    logic [2:0]       en_sy;
    logic [2:0]       uv_sy;
    logic [2:0]       fail_sy;
    logic             scl;
    logic             sda;
    logic             en;
    logic             uv;
    logic             fail;
    lpc_i2c_st_t      st;
    lpc_kind_t        kind;
    logic             rw;
    logic [3:0]       bits;
    logic [7:0]       sh;
    logic [7:0]       ptr;
    logic [3:0][7:0]  regs;
    logic             restart;
    logic             sda_o;
    logic             sda_oe;
    logic [5:0]       sink_on;
    logic             sink_hiz;
  } lpc_state_t;

endpackage

// ### common/lpc_seq_if.sv
// Link between the register side and the pump mode sequencer
// Assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface lpc_seq_if;
  logic               ce;
  logic               restart;
  logic               fail;
  lpc_pkg::lpc_pump_t mode;

  modport ctrl (output ce, output restart, output fail, input mode);
  modport seq  (input ce, input restart, input fail, output mode);
endinterface
`default_nettype wire

// ### core/lpc_pump_seq.sv
// Charge pump mode sequencer: 1x first, 1.5x after a held failure
// Assumes restart and fail are already synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.svh"
module lpc_pump_seq #(
  parameter int DELAY_CYC = `LPC_SWITCH_DELAY_CYC
) (
  // Clock and reset
  input wire logic   i_clk,
  input wire logic   i_nrst,
  // Sequencer link
  lpc_seq_if.seq     bus
);
  localparam int CW = $clog2(DELAY_CYC + 1);

  typedef struct packed {
    lpc_pkg::lpc_pump_t mode;
    logic [CW-1:0]      cnt;
  } lpc_seq_state_t;

  lpc_seq_state_t s;
  lpc_seq_state_t n;

  if (DELAY_CYC < 1) begin : g_chk
    $error("DELAY_CYC must be at least one cycle");
  end

  always_comb begin
    n = s;
    if (bus.restart) begin
      n.mode = lpc_pkg::PUMP_1X;
      n.cnt  = '0;
    end else if (s.mode == lpc_pkg::PUMP_1X) begin
      if (bus.fail) begin
        if (s.cnt == CW'(DELAY_CYC - 1)) begin
          n.mode = lpc_pkg::PUMP_1P5X;
          n.cnt  = '0;
        end else begin
          n.cnt = s.cnt + CW'(1);
        end
      end else begin
        n.cnt = '0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s <= '{mode: lpc_pkg::PUMP_1X, cnt: '0};
    end else if (bus.ce) begin
      s <= n;
    end
  end

  assign bus.mode = s.mode;

  property p_restart;
    @(posedge i_clk) disable iff (!i_nrst)
      (bus.ce && bus.restart) |=> (s.mode == lpc_pkg::PUMP_1X && s.cnt == '0);
  endproperty
  restart_to_1x_a :
    assert property (p_restart) else $error("restart did not return to 1x");

  switch_delay_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(s.mode) |-> $past(s.cnt) == CW'(DELAY_CYC - 1) && $past(bus.fail))
    else $error("1.5x entered before the full delay");

  stay_1x_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      (bus.ce && !bus.fail && s.mode == lpc_pkg::PUMP_1X) |=>
        s.mode == lpc_pkg::PUMP_1X)
    else $error("left 1x while regulation held");

  power_up_1x_a :
    assert property (@(posedge i_clk) !i_nrst |=> s.mode == lpc_pkg::PUMP_1X)
    else $error("pump not in 1x after reset");
endmodule
`default_nettype wire

// ### core/lpc_top.sv
// LED pair current control: serial register port, enable, lockout
// Assumes raw pins on i_scl, i_sda, i_en, i_supply_undervoltage_lockout, i_reg_fail
//
// How it works
// - Undervoltage lockout forces all six channels off.
// - Leaving shutdown keeps all channel currents at zero until programmed.
// - Enable held low keeps the device in shutdown.
// - Shutdown puts every sink output in high impedance, zero current.
// - Master writes and reads back all four registers over the bus.
// - Power-up starts the pump in 1x mode.
// - Pump stays in 1x while regulation holds.
// - Failing regulation in 1x switches to 1.5x after 400 us.
// - Power-up, shutdown exit and channel writes restart the mode sequence.
// - Each channel register write reselects the most efficient pump mode.
// - Configuration lives in four 8-bit registers.
// - Addresses 0,1,2 are pair A,B,C currents; 3 is channel on/off.
// - On/off bits 5..0 switch C2,C1,B2,B1,A2,A1; one means on.
// - Bits 7 and 6 of every register are unused.
// - Pair code in bits 5:0 selects 0.5 mA times code plus one.
// - Device answers only to slave address 1100110.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.svh"
module lpc_top #(
  parameter int SWITCH_DELAY_CYC = `LPC_SWITCH_DELAY_CYC
) (
  // Clock, reset, clock enable
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  input  wire logic                i_ce,
  // Serial register port
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output logic                     o_sda_o,
  output logic                     o_sda_oe,
  // Enable pin and analog status
  input  wire logic                i_en,
  input  wire logic                i_supply_undervoltage_lockout,
  input  wire logic                i_reg_fail,
  // Channel sink control
  output logic [5:0]               o_sink_on,
  output logic                     o_sink_hiz,
  output logic [`LPC_CODE_MSB:0]   o_pair_a_code,
  output logic [`LPC_CODE_MSB:0]   o_pair_b_code,
  output logic [`LPC_CODE_MSB:0]   o_pair_c_code,
  output lpc_pkg::lpc_pump_t       o_pump_mode
);
  lpc_pkg::lpc_state_t s;
  lpc_pkg::lpc_state_t n;
  logic                start;
  logic                stop;
  logic                rise;
  logic                fall;
  logic [7:0]          rd_data;

  lpc_seq_if seq_bus ();

  if (SWITCH_DELAY_CYC < 1) begin : g_chk
    $error("SWITCH_DELAY_CYC must be at least one cycle");
  end

  // Change accepted once second and third stages agree
  function automatic logic filt(input logic [2:0] sy, input logic cur);
    filt = (sy[1] == sy[2]) ? sy[2] : cur;
  endfunction

  function automatic logic [7:0] reg_read(input logic [3:0][7:0] regs,
                                          input logic [7:0] ptr);
    if (ptr < 8'(`LPC_REG_COUNT)) begin
      reg_read = regs[ptr[1:0]];
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  always_comb begin
    n         = s;
    n.restart = 1'b0;
    n.sda_o   = 1'b0;
    n.scl_sy  = {s.scl_sy[1:0], i_scl};
    n.sda_sy  = {s.sda_sy[1:0], i_sda};
    n.en_sy   = {s.en_sy[1:0], i_en};
    n.uv_sy   = {s.uv_sy[1:0], i_supply_undervoltage_lockout};
    n.fail_sy = {s.fail_sy[1:0], i_reg_fail};
    n.scl     = filt(s.scl_sy, s.scl);
    n.sda     = filt(s.sda_sy, s.sda);
    n.en      = filt(s.en_sy, s.en);
    n.uv      = filt(s.uv_sy, s.uv);
    n.fail    = filt(s.fail_sy, s.fail);
    start     = s.scl && n.scl && s.sda && !n.sda;
    stop      = s.scl && n.scl && !s.sda && n.sda;
    rise      = !s.scl && n.scl;
    fall      = s.scl && !n.scl;
    rd_data   = reg_read(s.regs, s.ptr);
    if (!n.en) begin
      n.regs   = '0;
      n.st     = lpc_pkg::I2C_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      // Also a repeated start after the pointer byte
      n.st     = lpc_pkg::I2C_RX;
      n.kind   = lpc_pkg::KB_ADDR;
      n.bits   = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st     = lpc_pkg::I2C_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (s.st)
        lpc_pkg::I2C_IDLE: begin
        end
        lpc_pkg::I2C_RX: begin
          if (rise && s.bits != 4'h8) begin
            n.sh   = {s.sh[6:0], n.sda};
            n.bits = s.bits + 4'h1;
          end else if (fall && s.bits == 4'h8) begin
            n.st     = lpc_pkg::I2C_ACK;
            n.sda_oe = 1'b1;
            unique case (s.kind)
              lpc_pkg::KB_ADDR: begin
                n.rw = s.sh[0];
                if (s.sh[7:1] != `LPC_SLAVE_ADDR) begin
                  n.st     = lpc_pkg::I2C_IDLE;
                  n.sda_oe = 1'b0;
                end
              end
              lpc_pkg::KB_PTR: begin
                n.ptr  = s.sh;
                n.kind = lpc_pkg::KB_DATA;
              end
              default: begin
                if (s.ptr < 8'(`LPC_REG_COUNT)) begin
                  // Bits 7:6 are dropped and read back as zero
                  n.regs[s.ptr[1:0]] = s.sh & `LPC_USED_MASK;
                end
                if (s.ptr == `LPC_REG_CHANNEL_ON_OFF) begin
                  n.restart = 1'b1;
                end
                n.ptr = s.ptr + 8'h01;
              end
            endcase
          end
        end
        lpc_pkg::I2C_ACK: begin
          if (fall) begin
            n.bits   = 4'h0;
            n.sda_oe = 1'b0;
            n.st     = lpc_pkg::I2C_RX;
            if (s.kind == lpc_pkg::KB_ADDR && s.rw) begin
              n.st     = lpc_pkg::I2C_TX;
              n.sh     = rd_data;
              n.sda_oe = !rd_data[7];
              n.ptr    = s.ptr + 8'h01;
            end else if (s.kind == lpc_pkg::KB_ADDR) begin
              n.kind = lpc_pkg::KB_PTR;
            end
          end
        end
        lpc_pkg::I2C_TX: begin
          if (rise) begin
            n.bits = s.bits + 4'h1;
          end else if (fall && s.bits == 4'h8) begin
            n.sda_oe = 1'b0;
            n.st     = lpc_pkg::I2C_RACK;
          end else if (fall) begin
            n.sh     = {s.sh[6:0], 1'b0};
            n.sda_oe = !s.sh[6];
          end
        end
        lpc_pkg::I2C_RACK: begin
          if (rise && n.sda) begin
            n.st = lpc_pkg::I2C_IDLE;
          end else if (fall) begin
            n.st     = lpc_pkg::I2C_TX;
            n.bits   = 4'h0;
            n.sh     = rd_data;
            n.sda_oe = !rd_data[7];
            n.ptr    = s.ptr + 8'h01;
          end
        end
        default: begin
          n.st     = lpc_pkg::I2C_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    if (n.en && !s.en) begin
      n.restart = 1'b1;
    end
    n.sink_hiz = !n.en;
    if (n.en && !n.uv) begin
      n.sink_on = n.regs[3][5:0];
    end else begin
      n.sink_on = 6'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s          <= '0;
      s.scl_sy   <= 3'h7;
      s.sda_sy   <= 3'h7;
      s.scl      <= 1'b1;
      s.sda      <= 1'b1;
      s.sink_hiz <= 1'b1;
    end else if (i_ce) begin
      s <= n;
    end
  end

  assign seq_bus.ce      = i_ce;
  assign seq_bus.restart = s.restart;
  assign seq_bus.fail    = s.fail;

  lpc_pump_seq #(
    .DELAY_CYC (SWITCH_DELAY_CYC)
  ) u_seq (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .bus    (seq_bus.seq)
  );

  // Pair codes select 0.5 mA times code plus one
  assign o_pair_a_code = s.regs[0][`LPC_CODE_MSB:0];
  assign o_pair_b_code = s.regs[1][`LPC_CODE_MSB:0];
  assign o_pair_c_code = s.regs[2][`LPC_CODE_MSB:0];
  assign o_sink_on     = s.sink_on;
  assign o_sink_hiz    = s.sink_hiz;
  assign o_sda_o       = s.sda_o;
  assign o_sda_oe      = s.sda_oe;
  assign o_pump_mode   = seq_bus.mode;

  supply_undervoltage_lockout_off_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      s.uv |-> o_sink_on == 6'h00)
    else $error("channel on during undervoltage");

  shutdown_clear_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      !s.en |-> s.regs == '0 && o_sink_hiz && o_sink_on == 6'h00)
    else $error("state not cleared in shutdown");

  wake_zero_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(s.en) |-> s.regs == '0 && s.restart)
    else $error("enable rise without zero currents and restart");

  on_off_map_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      (s.en && !s.uv) |-> o_sink_on == s.regs[3][5:0] && !o_sink_hiz)
    else $error("sink enables do not follow on/off register");

  unused_bits_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      (s.regs[0][7:6] | s.regs[1][7:6] | s.regs[2][7:6]
       | s.regs[3][7:6]) == 2'b00)
    else $error("unused bits stored");

  write_store_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && n.en && !start && !stop && s.st == lpc_pkg::I2C_RX
       && s.kind == lpc_pkg::KB_DATA && fall && s.bits == 4'h8
       && s.ptr < 8'h04)
      |=> s.regs[$past(s.ptr[1:0])] == ($past(s.sh) & 8'h3f))
    else $error("write did not reach addressed register");

  on_off_restart_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_ce && n.en && !start && !stop && s.st == lpc_pkg::I2C_RX
       && s.kind == lpc_pkg::KB_DATA && fall && s.bits == 4'h8
       && s.ptr == 8'h03) |=> s.restart ##1 o_pump_mode == lpc_pkg::PUMP_1X)
    else $error("channel write did not restart pump sequence");

  addr_match_a :
    assert property (@(posedge i_clk) disable iff (!i_nrst)
      (s.st == lpc_pkg::I2C_ACK && s.kind == lpc_pkg::KB_ADDR)
      |-> s.sh[7:1] == 7'h66)
    else $error("acknowledged a foreign address");
endmodule
`default_nettype wire

// ### tb/lpc_i2c_master.sv
// Serial bus master model for the register port
// Assumes SDA pulled up; the device pulls it low through i_sda_oe
`timescale 1ns/1ps
`default_nettype none
module lpc_i2c_master #(
  parameter int HALF = 10
) (
  // Clock and device pull-down
  input  wire logic i_clk,
  input  wire logic i_sda_oe,
  // Bus lines driven by the master, high = released
  output logic      o_scl,
  output logic      o_sda
);
  wire logic line = o_sda & !i_sda_oe;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Start or repeated start, SCL left low
  task automatic start();
    tick(HALF);
    o_sda <= 1'b1;
    tick(HALF);
    o_scl <= 1'b1;
    tick(HALF);
    o_sda <= 1'b0;
    tick(HALF);
    o_scl <= 1'b0;
  endtask

  task automatic stop();
    tick(HALF);
    o_sda <= 1'b0;
    tick(HALF);
    o_scl <= 1'b1;
    tick(HALF);
    o_sda <= 1'b1;
    tick(HALF);
  endtask

  // Eight bits and the acknowledge slot, MSB first
  task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(HALF);
      o_sda <= tx[i];
      tick(HALF);
      o_scl <= 1'b1;
      tick(HALF);
      rx[i] = line;
      o_scl <= 1'b0;
    end
  endtask

  task automatic write_reg(input logic [6:0] adr, input logic [7:0] ptr,
                           input logic [7:0] dat, output logic ack);
    logic [8:0] r0;
    logic [8:0] r1;
    logic [8:0] r2;
    start();
    byte9({adr, 1'b0, 1'b1}, r0);
    byte9({ptr, 1'b1}, r1);
    byte9({dat, 1'b1}, r2);
    stop();
    ack = !r0[0] && !r1[0] && !r2[0];
  endtask

  task automatic read_reg(input logic [6:0] adr, input logic [7:0] ptr,
                          output logic [7:0] dat, output logic ack);
    logic [8:0] r0;
    logic [8:0] r1;
    logic [8:0] r2;
    logic [8:0] r3;
    start();
    byte9({adr, 1'b0, 1'b1}, r0);
    byte9({ptr, 1'b1}, r1);
    start();
    byte9({adr, 1'b1, 1'b1}, r2);
    byte9(9'h1ff, r3);
    stop();
    dat = r3[8:1];
    ack = !r0[0] && !r1[0] && !r2[0];
  endtask
endmodule
`default_nettype wire

// ### tb/test_led_pair_current_control.sv
// Self-checking bench for the LED pair current control block
// Assumes lpc_top with a shortened switch delay of 20 cycles
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.svh"
module test_led_pair_current_control;
  logic               i_clk;
  logic               i_nrst;
  logic               i_ce;
  logic               i_en;
  logic               i_supply_undervoltage_lockout;
  logic               i_reg_fail;
  logic               scl;
  logic               sda;
  logic               o_sda_oe;
  logic               o_sda_o;
  logic               o_sink_hiz;
  logic [5:0]         o_sink_on;
  logic [5:0]         code_a;
  logic [5:0]         code_b;
  logic [5:0]         code_c;
  lpc_pkg::lpc_pump_t o_pump_mode;
  logic [7:0]         rd;
  logic               ack;
  int                 fails;
  int                 comparisons;
  wire logic          sda_line = sda & !o_sda_oe;
  logic [7:0]         vals [4] = '{8'hff, 8'hc1, 8'h9e, 8'hea};

  lpc_top #(.SWITCH_DELAY_CYC(20)) dut_u (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_scl(scl),
    .i_sda(sda_line), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_en(i_en),
    .i_supply_undervoltage_lockout(i_supply_undervoltage_lockout), .i_reg_fail(i_reg_fail), .o_sink_on(o_sink_on),
    .o_sink_hiz(o_sink_hiz), .o_pair_a_code(code_a),
    .o_pair_b_code(code_b), .o_pair_c_code(code_c),
    .o_pump_mode(o_pump_mode)
  );

  lpc_i2c_master master_u (
    .i_clk(i_clk), .i_sda_oe(o_sda_oe), .o_scl(scl), .o_sda(sda)
  );

  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic t_reset();
    settle(2);
    check({7'h00, o_sink_hiz}, 8'h01);
    check({2'b00, o_sink_on}, 8'h00);
    check({7'h00, o_pump_mode}, 8'h00);
    check({6'h00, o_sda_o, o_sda_oe}, 8'h00);
  endtask

  task automatic t_enable();
    @(posedge i_clk) i_en <= 1'b1;
    settle(10);
    check({7'h00, o_sink_hiz}, 8'h00);
    check({2'b00, o_sink_on}, 8'h00);
    check({2'b00, code_a}, 8'h00);
  endtask

  task automatic t_regs();
    // Unused channels off: only the second sink of each pair is fitted
    for (int i = 0; i < 4; i++) begin
      master_u.write_reg(`LPC_SLAVE_ADDR, 8'(i), vals[i], ack);
      check({7'h00, ack}, 8'h01);
    end
    for (int i = 0; i < 4; i++) begin
      master_u.read_reg(`LPC_SLAVE_ADDR, 8'(i), rd, ack);
      check(rd, vals[i] & `LPC_USED_MASK);
    end
    settle(1);
    check({2'b00, code_a}, 8'h3f);
    check({2'b00, code_b}, 8'h01);
    check({2'b00, code_c}, 8'h1e);
    check({2'b00, o_sink_on}, 8'h2a);
  endtask

  task automatic t_wrong_addr();
    master_u.write_reg(7'h33, 8'h00, 8'h05, ack);
    check({7'h00, ack}, 8'h00);
    check({2'b00, code_a}, 8'h3f);
  endtask

  task automatic t_pump();
    repeat (3) begin
      @(posedge i_clk) i_reg_fail <= 1'b1;
      settle(10);
      @(posedge i_clk) i_reg_fail <= 1'b0;
      settle(6);
    end
    check({7'h00, o_pump_mode}, 8'h00);
    @(posedge i_clk) i_reg_fail <= 1'b1;
    settle(15);
    check({7'h00, o_pump_mode}, 8'h00);
    settle(15);
    check({7'h00, o_pump_mode}, 8'h01);
    @(posedge i_clk) i_reg_fail <= 1'b0;
    settle(10);
    check({7'h00, o_pump_mode}, 8'h01);
    master_u.write_reg(`LPC_SLAVE_ADDR, `LPC_REG_CHANNEL_ON_OFF, 8'h2a, ack);
    settle(2);
    check({7'h00, o_pump_mode}, 8'h00);
  endtask

  task automatic t_supply_undervoltage_lockout();
    @(posedge i_clk) i_ce <= 1'b0;
    i_supply_undervoltage_lockout <= 1'b1;
    settle(8);
    // Clock enable low holds every output
    check({2'b00, o_sink_on}, 8'h2a);
    @(posedge i_clk) i_ce <= 1'b1;
    settle(8);
    check({2'b00, o_sink_on}, 8'h00);
    @(posedge i_clk) i_supply_undervoltage_lockout <= 1'b0;
    settle(8);
    check({2'b00, o_sink_on}, 8'h2a);
  endtask

  task automatic t_shutdown();
    @(posedge i_clk) i_en <= 1'b0;
    i_reg_fail <= 1'b1;
    settle(8);
    check({7'h00, o_sink_hiz}, 8'h01);
    check({2'b00, o_sink_on}, 8'h00);
    check({2'b00, code_a}, 8'h00);
    master_u.write_reg(`LPC_SLAVE_ADDR, 8'h00, 8'h11, ack);
    check({7'h00, ack}, 8'h00);
    // Pump moved to 1.5x so that the enable rise must restart it
    check({7'h00, o_pump_mode}, 8'h01);
    @(posedge i_clk) i_reg_fail <= 1'b0;
    settle(6);
    @(posedge i_clk) i_en <= 1'b1;
    settle(10);
    check({7'h00, o_sink_hiz}, 8'h00);
    check({7'h00, o_pump_mode}, 8'h00);
    master_u.read_reg(`LPC_SLAVE_ADDR, `LPC_REG_CHANNEL_ON_OFF, rd, ack);
    check(rd, `LPC_REG_RESET);
  endtask

  initial begin
    fails = 0;
    comparisons = 0;
    i_nrst = 1'b0;
    i_ce = 1'b1;
    i_en = 1'b0;
    i_supply_undervoltage_lockout = 1'b0;
    i_reg_fail = 1'b0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_enable();
    t_regs();
    t_wrong_addr();
    t_pump();
    t_supply_undervoltage_lockout();
    t_shutdown();
    conclude();
  end

  // Watchdog well beyond the roughly 12400 cycles the tests take
  initial begin
    repeat (100000) @(posedge i_clk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
